// ===== inc/ssb_defines.svh
// Constants for the sensor sample buffer: register addresses, sizes and widths.
// Assumes inclusion by bare name from any design or bench file.
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register addresses on the serial register interface
// ----------------------------------------------------------------------------
`define SSB_ADDR_CLEAR      8'h7E
`define SSB_ADDR_OUTPUT     8'h7F

// ----------------------------------------------------------------------------
// Store geometry
// ----------------------------------------------------------------------------
`define SSB_DEPTH_BYTES     1024
`define SSB_MAX_SET_BYTES   26
`define SSB_SET_LEN_W       5
`define SSB_THR_W           10
`define SSB_COUNT_W         11
`define SSB_MODE_W          2
`define SSB_EMPTY_BYTE      8'h00

`endif

// ===== inc/ssb_pkg.sv
// Types shared by the sensor sample buffer and its bench.
// Assumes ssb_defines.svh is on the include path.
`include "ssb_defines.svh"

package ssb_pkg;

    // ------------------------------------------------------------------------
    // Operating modes, in the order of the two-bit mode field
    // ------------------------------------------------------------------------
    typedef enum logic [`SSB_MODE_W-1:0] {
        SSB_OLDEST_STOP,
        SSB_STREAM,
        SSB_TRIGGER,
        SSB_NEWEST_FIRST
    } ssb_mode_e;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                    storeEnableBit;
        logic [`SSB_MODE_W-1:0]  mode;
        logic [`SSB_THR_W-1:0]   sampleThreshold;
        logic [`SSB_THR_W-1:0]   pretriggerThreshold;
        logic [`SSB_SET_LEN_W-1:0] setBytes;
    } ssb_cfg_s;

    typedef struct packed {
        logic [`SSB_MAX_SET_BYTES-1:0][7:0] bytes;
    } ssb_set_s;

    typedef struct packed {
        logic                    watermark;
        logic                    triggerStatusFlag;
        logic                    triggered;
        logic [`SSB_COUNT_W-1:0] storedSampleCount;
        logic [`SSB_COUNT_W-1:0] samplesAboveThreshold;
    } ssb_status_s;

endpackage

// ===== rtl/ssb_sample_buffer.sv
// Sensor sample buffer: byte store of whole data sets, four modes, watermark
// and trigger status, read out through the buffer output port.
// Assumes the serial interface decodes host accesses into one-cycle strobes
// with an address, and that data sets arrive whole, one strobe per sample tick.
`include "ssb_defines.svh"

// Contract
// - 1024-byte store with four selectable modes
// - Data sets arrive at highest sample rate
// - Oldest-first stop mode drops sets when full
// - Oldest-first stop reads oldest sample's first byte
// - Watermark when count reaches sample threshold, in every mode but trigger
// - Watermark holds until count below threshold
// - Streaming and newest-first overwrite oldest when full
// - Streaming and trigger modes read oldest first
// - Trigger input captures pre-event history then fills
// - Pre-event fill to threshold, then discard oldest
// - Post-event append until full, then stop
// - Trigger flag when event meets threshold count
// - Newest-first reads newest sample's last byte
// - Writes go sequentially to next free byte
// - Oldest-first reads remove the oldest sample
// - Newest-first reads remove only newest sample
// - Two-bit field selects the four modes
// - Clear write empties store and status, but a trigger event in the clear cycle survives
// - Read pointer advances each byte read
// - Collection only while enable bit set
module ssb_sample_buffer #(
    parameter int DEPTH = `SSB_DEPTH_BYTES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire ssb_pkg::ssb_cfg_s    cfg,
    input  wire logic                 setValid,
    input  wire ssb_pkg::ssb_set_s    dataSet,
    input  wire logic                 triggerInput,
    input  wire logic                 regReadStrobe,
    input  wire logic                 regWriteStrobe,
    input  wire logic [7:0]           regAddr,
    output logic [7:0]                readData,
    output ssb_pkg::ssb_status_s      status
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = AW + 1;
    localparam int CW = `SSB_COUNT_W;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0]                mem_q [DEPTH];
    logic [AW-1:0]             head_q;
    logic [AW-1:0]             head_d;
    logic [LW-1:0]             byteLevel_q;
    logic [LW-1:0]             byteLevel_d;
    logic [CW-1:0]             sampleLevel_q;
    logic [CW-1:0]             sampleLevel_d;
    logic [`SSB_SET_LEN_W-1:0] rdIdx_q;
    logic [`SSB_SET_LEN_W-1:0] rdIdx_d;
    logic                      triggered_q;
    logic                      trigFlag_q;
    logic                      watermark_q;
    logic [CW-1:0]             above_q;
    logic [7:0]                readData_q;

    // ------------------------------------------------------------------------
    // Decode and next-state arithmetic
    // ------------------------------------------------------------------------
    ssb_pkg::ssb_mode_e        mode;
    logic                      clearHit;
    logic                      readHit;
    logic                      rdDone;
    logic                      wrEn;
    logic                      dropOld;
    logic                      trigEvent;
    logic                      storeFull;
    logic [LW-1:0]             setLen;
    logic [LW-1:0]             levelAfterRead;
    logic [CW-1:0]             samplesAfterRead;
    logic [LW-1:0]             headAdvance;
    logic [LW-1:0]             levelAfterPops;
    logic [AW-1:0]             wrAddr;
    logic [AW-1:0]             rdAddr;
    logic [CW-1:0]             sampleThr;
    logic [CW-1:0]             pretrigThr;

    assign mode       = ssb_pkg::ssb_mode_e'(cfg.mode);
    assign setLen     = LW'(cfg.setBytes);
    assign sampleThr  = CW'(cfg.sampleThreshold);
    assign pretrigThr = CW'(cfg.pretriggerThreshold);
    assign clearHit   = regWriteStrobe && (regAddr == `SSB_ADDR_CLEAR);
    assign readHit    = regReadStrobe && (regAddr == `SSB_ADDR_OUTPUT);

    // A sample leaves the store only once its last byte has been read
    assign rdDone = readHit && (sampleLevel_q != '0)
                    && (rdIdx_q == (cfg.setBytes - `SSB_SET_LEN_W'(1)));

    assign trigEvent = cfg.storeEnableBit && (mode == ssb_pkg::SSB_TRIGGER)
                       && triggerInput && !triggered_q;

    always_comb begin
        levelAfterRead   = rdDone ? byteLevel_q - setLen : byteLevel_q;
        samplesAfterRead = rdDone ? sampleLevel_q - CW'(1) : sampleLevel_q;
        storeFull        = (levelAfterRead + setLen) > LW'(DEPTH);
        wrEn             = 1'b0;
        dropOld          = 1'b0;
        if (setValid && cfg.storeEnableBit && !clearHit) begin
            case (mode)
                ssb_pkg::SSB_OLDEST_STOP: begin
                    wrEn = !storeFull;
                end
                ssb_pkg::SSB_STREAM, ssb_pkg::SSB_NEWEST_FIRST: begin
                    wrEn    = 1'b1;
                    dropOld = storeFull && (samplesAfterRead != '0);
                end
                ssb_pkg::SSB_TRIGGER: begin
                    if (triggered_q) begin
                        wrEn = !storeFull;
                    end else if (samplesAfterRead < pretrigThr) begin
                        wrEn = !storeFull;
                    end else if (samplesAfterRead != '0) begin
                        wrEn    = 1'b1;
                        dropOld = 1'b1;
                    end else begin
                        wrEn = 1'b0;
                    end
                end
                default: begin
                    wrEn = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        headAdvance = dropOld ? setLen : '0;
        if (rdDone && (mode != ssb_pkg::SSB_NEWEST_FIRST)) begin
            headAdvance = headAdvance + setLen;
        end
        levelAfterPops = dropOld ? levelAfterRead - setLen : levelAfterRead;
        // Next free byte sits right behind the newest surviving byte
        wrAddr = AW'(LW'(head_q) + headAdvance + levelAfterPops);
    end

    always_comb begin
        if (clearHit) begin
            head_d        = '0;
            byteLevel_d   = '0;
            sampleLevel_d = '0;
        end else begin
            head_d        = AW'(LW'(head_q) + headAdvance);
            byteLevel_d   = wrEn ? levelAfterPops + setLen : levelAfterPops;
            sampleLevel_d = samplesAfterRead;
            if (dropOld) begin
                sampleLevel_d = sampleLevel_d - CW'(1);
            end
            if (wrEn) begin
                sampleLevel_d = sampleLevel_d + CW'(1);
            end
        end
    end

    // Byte cursor within the sample being read; a partial read keeps its place
    always_comb begin
        rdIdx_d = rdIdx_q;
        if (clearHit) begin
            rdIdx_d = '0;
        end else if (readHit && (sampleLevel_q != '0)) begin
            rdIdx_d = rdDone ? '0 : rdIdx_q + `SSB_SET_LEN_W'(1);
        end
    end

    // Oldest-first walks forward from the head, newest-first walks back from
    // the tail, so the newest sample comes out last byte first.
    always_comb begin
        if (mode == ssb_pkg::SSB_NEWEST_FIRST) begin
            rdAddr = AW'(LW'(head_q) + byteLevel_q - LW'(1) - LW'(rdIdx_q));
        end else begin
            rdAddr = AW'(LW'(head_q) + LW'(rdIdx_q));
        end
    end

    // ------------------------------------------------------------------------
    // Byte store
    // ------------------------------------------------------------------------
    // One set lands in a single cycle; each entry checks whether it falls in
    // the window starting at the write address. Trades area for a simple path.
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : gEntry
            logic [AW-1:0] offset;
            assign offset = AW'(i) - wrAddr;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    mem_q[i] <= `SSB_EMPTY_BYTE;
                end else if (wrEn && (LW'(offset) < setLen)) begin
                    mem_q[i] <= dataSet.bytes[`SSB_SET_LEN_W'(offset)];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Pointers and levels
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            head_q        <= '0;
            byteLevel_q   <= '0;
            sampleLevel_q <= '0;
            rdIdx_q       <= '0;
        end else begin
            head_q        <= head_d;
            byteLevel_q   <= byteLevel_d;
            sampleLevel_q <= sampleLevel_d;
            rdIdx_q       <= rdIdx_d;
        end
    end

    // ------------------------------------------------------------------------
    // Output port
    // ------------------------------------------------------------------------
    // Registered, so a byte is valid one cycle after the pointer moves
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readData_q <= `SSB_EMPTY_BYTE;
        end else if (sampleLevel_q == '0) begin
            readData_q <= `SSB_EMPTY_BYTE;
        end else begin
            readData_q <= mem_q[rdAddr];
        end
    end

    // ------------------------------------------------------------------------
    // Trigger state
    // ------------------------------------------------------------------------
    // An event in the clear cycle survives the clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            triggered_q <= 1'b0;
        end else if (trigEvent) begin
            triggered_q <= 1'b1;
        end else if (clearHit) begin
            triggered_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trigFlag_q <= 1'b0;
        end else if (trigEvent && (sampleLevel_q >= pretrigThr)) begin
            trigFlag_q <= 1'b1;
        end else if (clearHit) begin
            trigFlag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Watermark and level reporting
    // ------------------------------------------------------------------------
    // Level-driven, so it drops by itself once reads or a clear go below
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            watermark_q <= 1'b0;
        end else begin
            watermark_q <= cfg.storeEnableBit && (mode != ssb_pkg::SSB_TRIGGER)
                           && (sampleLevel_d >= sampleThr);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            above_q <= '0;
        end else if (sampleLevel_d >= sampleThr) begin
            above_q <= sampleLevel_d - sampleThr;
        end else begin
            above_q <= '0;
        end
    end

    assign readData                     = readData_q;
    assign status.watermark             = watermark_q;
    assign status.triggerStatusFlag     = trigFlag_q;
    assign status.triggered             = triggered_q;
    assign status.storedSampleCount     = sampleLevel_q;
    assign status.samplesAboveThreshold = above_q;

endmodule

// ===== tb/ssb_host_model.sv
// Host model: register reads and clear writes on the strobe interface.
// Assumes the bench calls access(); strobes move only at the falling edge.
module ssb_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] readData,
    output logic            regReadStrobe,
    output logic            regWriteStrobe,
    output logic [7:0]      regAddr
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        regReadStrobe  = 1'b0;
        regWriteStrobe = 1'b0;
        regAddr        = 8'h00;
    end

    // Byte is taken before the strobe; the return to the caller's next negedge
    // keeps strobes two edges apart, the tightest spacing the port allows
    task automatic access(input logic wr, input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        data           = readData;
        regAddr        = addr;
        regReadStrobe  = !wr;
        regWriteStrobe = wr;
        @(negedge ref_clk);
        regReadStrobe  = 1'b0;
        regWriteStrobe = 1'b0;
        regAddr        = ~addr;
    endtask
endmodule

// ===== tb/ssb_sample_buffer_assertions.sv
// Checker for the sample buffer, bound to its ports.
// Assumes one clock domain and a set size held constant between clears.
`include "ssb_defines.svh"
module ssb_sample_buffer_checker #(
    parameter int DEPTH = `SSB_DEPTH_BYTES
) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire ssb_pkg::ssb_cfg_s    cfg,
    input wire logic                 setValid,
    input wire logic                 triggerInput,
    input wire logic                 regReadStrobe,
    input wire logic                 regWriteStrobe,
    input wire logic [7:0]           regAddr,
    input wire logic [7:0]           readData,
    input wire ssb_pkg::ssb_status_s status
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire logic       clearHit = regWriteStrobe && regAddr == `SSB_ADDR_CLEAR;
    wire logic       readHit  = regReadStrobe && regAddr == `SSB_ADDR_OUTPUT;
    wire logic [10:0] cnt     = status.storedSampleCount;
    wire logic [10:0] thr     = {1'b0, cfg.sampleThreshold};
    wire logic       wmMode   = cfg.storeEnableBit && cfg.mode != ssb_pkg::SSB_TRIGGER;

    clear_empties_a: assert property (clearHit && !triggerInput |=> cnt == 11'h000
        && !status.watermark && !status.triggered) else $error("clear left state");
    first_write_a: assert property (setValid && cfg.storeEnableBit && !clearHit && !readHit
        && cfg.mode != ssb_pkg::SSB_TRIGGER && cnt == 11'h000 |=> cnt == 11'h001)
        else $error("set not stored");
    disabled_hold_a: assert property (!cfg.storeEnableBit && !readHit && !clearHit
        |=> $stable(cnt)) else $error("store changed while disabled");
    wm_high_a: assert property ((wmMode && cnt >= thr)[*2] |-> status.watermark)
        else $error("watermark missing");
    wm_low_a: assert property ((cnt < thr || !cfg.storeEnableBit)[*2] |-> !status.watermark)
        else $error("watermark stuck");
    trigger_input_flag_a: assert property (cfg.mode == ssb_pkg::SSB_TRIGGER && cfg.storeEnableBit
        && triggerInput && !status.triggered && !clearHit
        && cnt >= {1'b0, cfg.pretriggerThreshold} |=> status.triggered && status.triggerStatusFlag)
        else $error("trigger flag missing");
    trigger_input_cause_a: assert property ($rose(status.triggered) |-> $past(triggerInput)
        && $past(cfg.mode) == ssb_pkg::SSB_TRIGGER) else $error("trigger without cause");
    cap_bound_a: assert property (cnt * cfg.setBytes <= DEPTH)
        else $error("store beyond capacity");
    above_cnt_a: assert property ($stable(cfg.sampleThreshold) |-> status.samplesAboveThreshold
        == (cnt >= thr ? cnt - thr : 11'h000)) else $error("samples above threshold wrong");

    cover property ($rose(status.watermark));
    cover property ($rose(status.triggerStatusFlag));
    cover property (readHit && cnt != 11'h000);
endmodule

bind ssb_sample_buffer ssb_sample_buffer_checker #(.DEPTH(DEPTH)) i_chk (.ref_clk, .rst, .cfg,
    .setValid, .triggerInput, .regReadStrobe, .regWriteStrobe, .regAddr, .readData, .status);

// ===== tb/testbench.sv
// Bench for the sample buffer: a 16-byte store of four 4-byte sets.
// Assumes the host model for register traffic; bench inputs move at negedge.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [1:0] mode; int nw; logic [10:0] cnt; int first;} ssb_row_s;

    logic                 ref_clk;
    logic                 rst;
    ssb_pkg::ssb_cfg_s    cfg;
    logic                 setValid;
    ssb_pkg::ssb_set_s    dataSet;
    logic                 triggerInput;
    logic                 regReadStrobe;
    logic                 regWriteStrobe;
    logic [7:0]           regAddr;
    logic [7:0]           readData;
    ssb_pkg::ssb_status_s status;
    logic [7:0]           b;
    int                   num_errors = 0;
    int                   check_count = 0;
    // Mode, sets written, count expected, first set read back
    ssb_row_s rows [5] = '{'{2'h0, 6, 11'h004, 0}, '{2'h1, 6, 11'h004, 2},
        '{2'h3, 6, 11'h004, 5}, '{2'h0, 2, 11'h002, 0}, '{2'h3, 2, 11'h002, 1}};

    ssb_sample_buffer #(.DEPTH(16)) i_dut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
        .setValid(setValid), .dataSet(dataSet), .triggerInput(triggerInput),
        .regReadStrobe(regReadStrobe), .regWriteStrobe(regWriteStrobe), .regAddr(regAddr),
        .readData(readData), .status(status));
    ssb_host_model i_host (.ref_clk(ref_clk), .readData(readData),
        .regReadStrobe(regReadStrobe), .regWriteStrobe(regWriteStrobe), .regAddr(regAddr));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic note(input bit bad, input string what, input logic [10:0] exp, got);
        check_count++;
        if (bad) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, got);
        note(got !== exp, what, 11'(exp), 11'(got));
    endtask
    task automatic chk_cnt(input string what, input logic [10:0] exp, got);
        note(got !== exp, what, exp, got);
    endtask
    task automatic chk_bit(input string what, input logic exp, got);
        note(got !== exp, what, 11'(exp), 11'(got));
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic put_set(input int n);
        @(negedge ref_clk);
        for (int i = 0; i < 26; i++) dataSet.bytes[i] = 8'(n * 16 + i);
        setValid = 1'b1;
        @(negedge ref_clk);
        setValid = 1'b0;
        dataSet  = ~dataSet;
    endtask
    // Newest-first hands the bytes of a set out last to first
    task automatic get_set(input int n, input bit rev);
        for (int i = 0; i < 4; i++) begin
            i_host.access(1'b0, `SSB_ADDR_OUTPUT, b);
            chk_byte("read byte", 8'(rev ? n * 16 + 3 - i : n * 16 + i), b);
        end
    endtask
    task automatic pulse_trigger();
        @(negedge ref_clk);
        triggerInput = 1'b1;
        @(negedge ref_clk);
        triggerInput = 1'b0;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cfg = '{storeEnableBit: 1'b1, mode: 2'h0, sampleThreshold: 10'h003,
            pretriggerThreshold: 10'h002, setBytes: 5'h04};
        setValid = 1'b0;
        dataSet = '0;
        triggerInput = 1'b0;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        chk_cnt("reset count", 11'h000, status.storedSampleCount);
        i_host.access(1'b0, `SSB_ADDR_OUTPUT, b);
        chk_byte("empty read", 8'h00, b);
        foreach (rows[r]) begin
            cfg.mode = rows[r].mode;
            i_host.access(1'b1, `SSB_ADDR_CLEAR, b);
            for (int n = 0; n < rows[r].nw; n++) put_set(n);
            chk_cnt("count", rows[r].cnt, status.storedSampleCount);
            @(negedge ref_clk);
            chk_bit("watermark", rows[r].cnt >= 11'h003, status.watermark);
            chk_cnt("above threshold", (rows[r].cnt >= 11'h003) ? rows[r].cnt - 11'h003 : 11'h000,
                status.samplesAboveThreshold);
            get_set(rows[r].first, rows[r].mode == 2'h3);
            chk_cnt("count after read", rows[r].cnt - 11'h001, status.storedSampleCount);
            get_set(rows[r].first + (rows[r].mode == 2'h3 ? -1 : 1), rows[r].mode == 2'h3);
            @(negedge ref_clk);
            chk_bit("watermark after reads", 1'b0, status.watermark);
        end
        i_host.access(1'b1, `SSB_ADDR_CLEAR, b);
        put_set(7);
        i_host.access(1'b0, 8'h7D, b);
        i_host.access(1'b1, `SSB_ADDR_OUTPUT, b);
        chk_cnt("other address", 11'h001, status.storedSampleCount);
        cfg.storeEnableBit = 1'b0;
        put_set(8);
        chk_cnt("disabled", 11'h001, status.storedSampleCount);
        cfg.storeEnableBit = 1'b1;
        cfg.mode = ssb_pkg::SSB_TRIGGER;
        i_host.access(1'b1, `SSB_ADDR_CLEAR, b);
        for (int n = 0; n < 3; n++) put_set(n);
        chk_cnt("pre-event", 11'h002, status.storedSampleCount);
        pulse_trigger();
        chk_bit("triggered", 1'b1, status.triggered);
        chk_bit("trigger flag", 1'b1, status.triggerStatusFlag);
        for (int n = 3; n < 7; n++) put_set(n);
        chk_cnt("post-event", 11'h004, status.storedSampleCount);
        chk_bit("no watermark in trigger", 1'b0, status.watermark);
        get_set(1, 1'b0);
        i_host.access(1'b1, `SSB_ADDR_CLEAR, b);
        chk_bit("flag cleared", 1'b0, status.triggerStatusFlag);
        put_set(0);
        pulse_trigger();
        chk_bit("early trigger", 1'b1, status.triggered);
        chk_bit("early flag", 1'b0, status.triggerStatusFlag);
        wrap_up();
    end
endmodule
